/* File: ufl_channel.sv */
/*
 * one serial channel: apb register file, baud tick, transmitter with
 * infrared encoder, receiver with infrared decoder, receive fifo,
 * hardware flow control and internal loopback.
 * assumes pclk at 50 MHz, asynchronous pins synchronised here.
 */
// The implementer's own choice: the APB interface to the registers.
module ufl_channel
    import ufl_pkg::*;
#(
    parameter int RX_DEPTH = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [5:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial and modem pins
    input wire logic rx_pin,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic cd_n,
    input wire logic ri_n,
    input wire logic infrared_startup_pin,
    output logic tx_pin,
    output logic rts_n,
    output logic dtr_n
);
    localparam int CW = $clog2(RX_DEPTH + 1);
    localparam int AW = $clog2(RX_DEPTH);

    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ufl_tx_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RUN = 2'b10} ufl_rx_t;

    function automatic logic [7:0] ufl_ext8(input logic [CW-1:0] v);
        ufl_ext8 = 8'(v);
    endfunction : ufl_ext8

    // register storage
    logic [7:0] dll_q, dlm_q, dld_q, ier_q, lcr_q, mcr_q, spr_q, feature_control_q, efr_q;
    logic [7:0] rs485_dly_q, txtrig_q, rxtrig_q, fcr_q;
    logic [7:0] xchar_q [4];
    logic [7:0] thr_q;
    logic thr_full_q, isr_dflow_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, tx_pin_q, rts_n_q, dtr_n_q;

    // bus decode
    logic [3:0] idx;
    logic addr_err, dlab, unlock, acc, wr_en, rd_setup;
    assign idx = paddr[5:2];
    assign addr_err = paddr[1:0] != 2'b00;
    assign dlab = lcr_q[LCR_DLAB];
    assign unlock = efr_q[EFR_UNLOCK];
    assign acc = psel & penable & pready_q;
    assign wr_en = acc & pwrite & ~addr_err;
    assign rd_setup = psel & ~penable & ~pready_q & ~pwrite & ~addr_err;

    // pin synchronisers: {strap, ri, cd, dsr, cts, rx}
    logic [5:0] s1_q, s2_q, s3_q, pin_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= PIN_RESET;
            s2_q <= PIN_RESET;
            s3_q <= PIN_RESET;
            pin_q <= PIN_RESET;
        end else begin
            s1_q <= {infrared_startup_pin, ri_n, cd_n, dsr_n, cts_n, rx_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            // a change counts only once the last two stages agree
            for (int i = 0; i < 6; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
        end
    end

    logic loop, ir_on, flow_sel;
    assign loop = mcr_q[MCR_LOOP];
    assign ir_on = mcr_q[MCR_IR];
    assign flow_sel = mcr_q[MCR_FLOW_SEL];

    // baud tick at 16x bit rate
    logic [15:0] div, div_m1, bcnt_q;
    logic tick_q;
    assign div = {dlm_q, dll_q};
    assign div_m1 = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (bcnt_q >= div_m1) begin
            bcnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            bcnt_q <= bcnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // flow input of the chosen pair; modem inputs ignored in loopback
    logic flow_in_n, flow_prev_q, flow_stop;
    assign flow_in_n = loop ? 1'b0 : (flow_sel ? pin_q[2] : pin_q[1]);
    assign flow_stop = efr_q[EFR_AUTO_CTS] & flow_in_n;

    // transmitter
    ufl_tx_t tx_state_q;
    logic [3:0] tx_sub_q, tx_bit_q;
    logic [9:0] tx_shift_q;
    logic tx_ser, tx_busy, tx_start;
    assign tx_busy = tx_state_q == TX_SEND;
    assign tx_ser = tx_busy ? tx_shift_q[0] : 1'b1;
    // gating is only looked at between characters so none is cut short
    assign tx_start = (tx_state_q == TX_IDLE) & tick_q & thr_full_q & ~flow_stop;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= TX_IDLE;
            tx_sub_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_shift_q <= 10'h3ff;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_shift_q <= {1'b1, thr_q, 1'b0};
                        tx_sub_q <= 4'h0;
                        tx_bit_q <= 4'h0;
                        tx_state_q <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tick_q) begin
                        tx_sub_q <= tx_sub_q + 4'h1;
                        if (tx_sub_q == TICK_LAST) begin
                            tx_shift_q <= {1'b1, tx_shift_q[9:1]};
                            tx_bit_q <= tx_bit_q + 4'h1;
                            if (tx_bit_q == FRAME_LAST) begin
                                tx_state_q <= TX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // infrared encoder pulse for zero bits
    logic [3:0] ir_width;
    logic ir_pulse;
    assign ir_width = dld_q[DLD_FAST_IR] ? IR_WIDTH_FAST : IR_WIDTH_STD;
    assign ir_pulse = tx_busy & ~tx_shift_q[0] & (tx_sub_q < ir_width);

    // pin drivers; loopback parks all three pins high, the inactive state except for tx in infrared mode
    logic rts_allow_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pin_q <= 1'b1;
            rts_n_q <= 1'b1;
            dtr_n_q <= 1'b1;
        end else begin
            tx_pin_q <= loop ? 1'b1 : (ir_on ? ir_pulse : tx_ser);
            rts_n_q <= loop | ~(mcr_q[MCR_RTS] & (flow_sel | ~efr_q[EFR_AUTO_RTS] | rts_allow_q));
            dtr_n_q <= loop | ~(mcr_q[MCR_DTR] & (~flow_sel | ~efr_q[EFR_AUTO_RTS] | rts_allow_q));
        end
    end
    assign tx_pin = tx_pin_q;
    assign rts_n = rts_n_q;
    assign dtr_n = dtr_n_q;

    // infrared decoder: each pulse stretched to one zero bit
    logic ir_level;
    logic [4:0] ir_hold_q;
    assign ir_level = (pin_q[0] ^ feature_control_q[FEATURE_CONTROL_IR_INV]) & ~tx_busy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ir_hold_q <= 5'h00;
        end else if (ir_level) begin
            ir_hold_q <= 5'h10;
        end else if (tick_q && ir_hold_q != 5'h00) begin
            ir_hold_q <= ir_hold_q - 5'h01;
        end
    end

    logic rx_line;
    assign rx_line = loop ? tx_ser : (ir_on ? (ir_hold_q == 5'h00) : pin_q[0]);

    // receiver
    ufl_rx_t rx_state_q;
    logic [3:0] rx_sub_q, rx_bit_q;
    logic [7:0] rx_shift_q;
    logic rx_push;
    assign rx_push = (rx_state_q == RX_RUN) & tick_q & (rx_sub_q == TICK_MID) & (rx_bit_q == FRAME_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= RX_IDLE;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 8'h00;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: begin
                    if (tick_q && !rx_line) begin
                        rx_sub_q <= 4'h0;
                        rx_bit_q <= 4'h0;
                        rx_state_q <= RX_RUN;
                    end
                end
                RX_RUN: begin
                    if (tick_q) begin
                        rx_sub_q <= rx_sub_q + 4'h1;
                        if (rx_sub_q == TICK_MID) begin
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == 4'h0 && rx_line) begin
                                rx_state_q <= RX_IDLE;
                            end else if (rx_bit_q == FRAME_LAST) begin
                                rx_state_q <= RX_IDLE;
                            end else if (rx_bit_q != 4'h0) begin
                                rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                            end
                        end
                    end
                end
            endcase
        end
    end

    // receive fifo; a full fifo drops the new character
    logic [7:0] rx_mem_q [RX_DEPTH];
    logic [AW-1:0] rx_wp_q, rx_rp_q;
    logic [CW-1:0] rx_cnt_q;
    logic do_push, do_pop, rx_flush;
    assign rx_flush = wr_en & ~dlab & (idx == REG_ISR) & pwdata[FCR_RX_RESET];
    assign do_push = rx_push & (ufl_ext8(rx_cnt_q) < 8'(RX_DEPTH));
    assign do_pop = rd_setup & ~dlab & (idx == REG_HOLD) & (rx_cnt_q != '0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
            for (int i = 0; i < RX_DEPTH; i++) begin
                rx_mem_q[i] <= 8'h00;
            end
        end else if (rx_flush) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            if (do_push) begin
                rx_mem_q[rx_wp_q] <= rx_shift_q;
                rx_wp_q <= AW'((32'(rx_wp_q) + 1) % RX_DEPTH);
            end
            if (do_pop) begin
                rx_rp_q <= AW'((32'(rx_rp_q) + 1) % RX_DEPTH);
            end
            rx_cnt_q <= rx_cnt_q + CW'(do_push) - CW'(do_pop);
        end
    end

    // auto rts hysteresis around the receive trigger level
    logic [7:0] rx_lower;
    assign rx_lower = (rxtrig_q > {4'h0, feature_control_q[3:0]}) ? rxtrig_q - {4'h0, feature_control_q[3:0]} : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_allow_q <= 1'b1;
        end else if (ufl_ext8(rx_cnt_q) >= rxtrig_q) begin
            rts_allow_q <= 1'b0;
        end else if (ufl_ext8(rx_cnt_q) <= rx_lower) begin
            rts_allow_q <= 1'b1;
        end
    end

    // delta-flow status: a new event beats the clear from an isr read
    logic flow_rise, rts_drop, isr_clear, rts_prev_q;
    assign flow_rise = flow_in_n & ~flow_prev_q & ier_q[IER_CTS_INT];
    assign rts_drop = rts_prev_q & ~rts_allow_q & efr_q[EFR_AUTO_RTS] & ier_q[IER_RTS_INT];
    assign isr_clear = rd_setup & ~dlab & (idx == REG_ISR);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_prev_q <= 1'b0;
            rts_prev_q <= 1'b1;
            isr_dflow_q <= 1'b0;
        end else begin
            flow_prev_q <= flow_in_n;
            rts_prev_q <= rts_allow_q;
            if (flow_rise || rts_drop) begin
                isr_dflow_q <= 1'b1;
            end else if (isr_clear) begin
                isr_dflow_q <= 1'b0;
            end
        end
    end

    // register writes, strap catch and holding register
    logic [2:0] init_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {dll_q, dlm_q, dld_q} <= {DLL_RESET, REG_RESET, REG_RESET};
            {ier_q, lcr_q, mcr_q, spr_q, feature_control_q, efr_q} <= {6{REG_RESET}};
            {rs485_dly_q, txtrig_q, fcr_q} <= {3{REG_RESET}};
            rxtrig_q <= RXTRIG_RESET;
            for (int i = 0; i < 4; i++) begin
                xchar_q[i] <= REG_RESET;
            end
            thr_q <= REG_RESET;
            thr_full_q <= 1'b0;
            init_q <= 3'h0;
        end else begin
            if (init_q != STRAP_WAIT) begin
                init_q <= init_q + 3'h1;
            end
            // strap is read once the synchroniser holds a settled level
            if (init_q == STRAP_WAIT - 3'h1) begin
                mcr_q[MCR_IR] <= pin_q[5];
            end
            if (tx_start) begin
                thr_full_q <= 1'b0;
            end
            if (wr_en) begin
                unique case (idx)
                    REG_HOLD: begin
                        if (dlab) begin
                            dll_q <= pwdata[7:0];
                        end else begin
                            thr_q <= pwdata[7:0];
                            thr_full_q <= 1'b1;
                        end
                    end
                    REG_IER: begin
                        if (dlab) begin
                            dlm_q <= pwdata[7:0];
                        end else begin
                            // enhanced enables only move while unlocked
                            ier_q <= unlock ? pwdata[7:0] : {ier_q[7:4], pwdata[3:0]};
                        end
                    end
                    REG_ISR: begin
                        if (dlab) begin
                            dld_q <= pwdata[7:0];
                        end else begin
                            fcr_q <= pwdata[7:0];
                            if (pwdata[FCR_TX_RESET]) begin
                                thr_full_q <= 1'b0;
                            end
                        end
                    end
                    REG_LCR: lcr_q <= pwdata[7:0];
                    REG_MCR: mcr_q <= pwdata[7:0];
                    REG_MSR: begin
                        if (unlock) begin
                            rs485_dly_q <= pwdata[7:0];
                        end
                    end
                    REG_SPR: spr_q <= pwdata[7:0];
                    REG_FEATURE_CONTROL: feature_control_q <= pwdata[7:0];
                    REG_EFR: efr_q <= pwdata[7:0];
                    REG_TX_FIFO_LEVEL: txtrig_q <= pwdata[7:0];
                    REG_RX_FIFO_LEVEL: rxtrig_q <= pwdata[7:0];
                    REG_XOFF1, REG_XOFF2, REG_XON1, REG_XON2: xchar_q[idx[1:0]] <= pwdata[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // read mux; modem status ignores the pins in loopback
    logic [7:0] rd_byte;
    logic [3:0] modem_in;
    assign modem_in = loop ? 4'h0 : ~{pin_q[4], pin_q[3], pin_q[2], pin_q[1]};
    always_comb begin
        rd_byte = 8'h00;
        unique case (idx)
            REG_HOLD: rd_byte = dlab ? dll_q : rx_mem_q[rx_rp_q];
            REG_IER: rd_byte = dlab ? dlm_q : ier_q;
            REG_ISR: rd_byte = dlab ? dld_q : {fcr_q[0], fcr_q[0], isr_dflow_q, 5'h01};
            REG_LCR: rd_byte = lcr_q;
            REG_MCR: rd_byte = mcr_q;
            REG_LSR: rd_byte = {1'b0, ~tx_busy & ~thr_full_q, ~thr_full_q, 4'h0, rx_cnt_q != '0};
            REG_MSR: rd_byte = {modem_in, 4'h0};
            REG_SPR: rd_byte = spr_q;
            REG_FEATURE_CONTROL: rd_byte = feature_control_q;
            REG_EFR: rd_byte = efr_q;
            REG_TX_FIFO_LEVEL: rd_byte = {7'h00, thr_full_q};
            REG_RX_FIFO_LEVEL: rd_byte = ufl_ext8(rx_cnt_q);
            REG_XOFF1: rd_byte = 8'h00;
            default: rd_byte = 8'h00;
        endcase
    end

    // apb: data latched in setup, ready for exactly one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (psel && !penable && !pready_q) begin
            prdata_q <= addr_err ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pready_q <= 1'b1;
            pslverr_q <= addr_err;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_loop_tx_mark: assert property (loop |=> tx_pin_q)
        else $error("tx pin not mark in loopback");
    a_loop_modem_off: assert property (loop |=> rts_n_q && dtr_n_q)
        else $error("rts or dtr asserted in loopback");
    a_ir_idle_low: assert property (ir_on && !loop && !tx_busy |=> !tx_pin_q)
        else $error("infrared output not idle low");
    a_ir_pulse_end: assert property (tx_busy && ir_on && !loop && tx_sub_q == ir_width |=> !tx_pin_q)
        else $error("infrared pulse too wide");
    a_cts_gate_hold: assert property (!tx_busy && flow_stop |=> !tx_busy)
        else $error("transmit started while flow stopped");
    a_dflow_set: assert property (flow_rise |=> isr_dflow_q)
        else $error("delta flow bit not set");
    a_rts_drop: assert property (efr_q[EFR_AUTO_RTS] && !flow_sel && !loop && !rts_allow_q |=> rts_n_q)
        else $error("rts still asserted above threshold");
    a_dlab_map: assert property (rd_setup && dlab && idx == REG_HOLD |=> prdata_q[7:0] == $past(dll_q))
        else $error("divisor low not mapped at offset 0");
    a_apb_ready: assert property (psel && !penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("ready not a single access cycle");
endmodule : ufl_channel

/* File: ufl_pkg.sv */
/*
 * shared constants of one enhanced serial channel: register indices,
 * field positions, reset values and bit timing.
 * assumes a 32-bit apb bus where register index n sits at byte address 4*n.
 */
// Notes on behaviour
// - auto cts gating and auto rts control enabled separately by enhanced bits 7 and 6.
// - modem control bit 2 picks rts/cts pair or dtr/dsr pair for flow control.
// - auto cts: input going high stops transmit after current stop bit; low resumes.
// - flow input de-asserted with its interrupt enabled sets delta-flow status bit 5.
// - auto rts drops output at upper fill threshold, restores at lower threshold.
// - infrared startup pin sets the infrared enable bit at reset; software may change it.
// - in infrared mode the receiver is blind while the transmitter sends.
// - infrared mode: transmit output idles low, receive input low means idle.
// - encoder sends a 3/16 bit pulse for each zero bit, none for ones.
// - fast infrared bit of divisor fraction makes pulses a quarter bit wide.
// - decoder returns a zero bit for every light pulse seen.
// - a register bit can invert the receive input ahead of the decoder.
// - loopback bit routes transmit shifter output into the receive shifter.
// - loopback holds transmit pin high, de-asserts rts and dtr, ignores modem inputs.
// - four address bits select 16 registers, upper eight are enhanced ones.
// - divisor latch bit switches offsets 0 to 2 to divisor low, high, fraction.
// - offset 6 reads modem status; with unlock set a write loads turnaround delay.
// - offsets 10 and 11 read fill counts and write trigger levels.
// - offsets 12 to 15 store xon/xoff characters; read of 12 gives flags (this design always reads 0 there).
package ufl_pkg;
    // register indices
    localparam logic [3:0] REG_HOLD = 4'h0;
    localparam logic [3:0] REG_IER = 4'h1;
    localparam logic [3:0] REG_ISR = 4'h2;
    localparam logic [3:0] REG_LCR = 4'h3;
    localparam logic [3:0] REG_MCR = 4'h4;
    localparam logic [3:0] REG_LSR = 4'h5;
    localparam logic [3:0] REG_MSR = 4'h6;
    localparam logic [3:0] REG_SPR = 4'h7;
    localparam logic [3:0] REG_FEATURE_CONTROL = 4'h8;
    localparam logic [3:0] REG_EFR = 4'h9;
    localparam logic [3:0] REG_TX_FIFO_LEVEL = 4'ha;
    localparam logic [3:0] REG_RX_FIFO_LEVEL = 4'hb;
    localparam logic [3:0] REG_XOFF1 = 4'hc;
    localparam logic [3:0] REG_XOFF2 = 4'hd;
    localparam logic [3:0] REG_XON1 = 4'he;
    localparam logic [3:0] REG_XON2 = 4'hf;
    // field positions
    localparam int EFR_AUTO_CTS = 7;
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_UNLOCK = 4;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_FLOW_SEL = 2;
    localparam int MCR_LOOP = 4;
    localparam int MCR_IR = 6;
    localparam int LCR_DLAB = 7;
    localparam int IER_CTS_INT = 7;
    localparam int IER_RTS_INT = 6;
    localparam int ISR_DFLOW = 5;
    localparam int DLD_FAST_IR = 4;
    localparam int FEATURE_CONTROL_IR_INV = 4;
    localparam int FCR_RX_RESET = 1;
    localparam int FCR_TX_RESET = 2;
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DLL_RESET = 8'h01;
    localparam logic [7:0] RXTRIG_RESET = 8'h08;
    localparam logic [5:0] PIN_RESET = 6'h1f;
    // bit timing in 16x ticks, strap wait in pclk cycles
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] IR_WIDTH_STD = 4'h3;
    localparam logic [3:0] IR_WIDTH_FAST = 4'h4;
    localparam logic [3:0] FRAME_LAST = 4'h9;
    localparam logic [2:0] STRAP_WAIT = 3'h5;
endpackage : ufl_pkg

/* File: ufl_remote_port.sv */
/* remote serial port as seen from the channel pins.
   assumes the bench commands the hold-off levels and infrared mode. */
module ufl_remote_port (
    // commands from the bench
    input wire logic [1:0] hold_off,
    input wire logic ir_mode,
    // channel pins
    output logic rx_pin,
    output logic cts_n,
    output logic dsr_n,
    output logic cd_n,
    output logic ri_n
);
    // a high flow input asks the channel to pause after its current char
    assign cts_n = hold_off[0];
    assign dsr_n = hold_off[1];
    // carrier present, no ring: loopback must hide these from status
    assign cd_n = 1'b0;
    assign ri_n = 1'b1;
    // remote never sends, so the line rests at the idle level of the mode
    assign rx_pin = ~ir_mode;
endmodule : ufl_remote_port

/* File: tb_ufl_channel.sv */
/* self-checking bench of one serial channel: registers, loopback, flow, infrared.
   assumes the channel, its package and the remote port model are compiled first. */
module tb_ufl_channel import ufl_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ir_mode = 0, strap = 0, err;
    logic [1:0] hold_off = 2'b00;
    logic [5:0] paddr = 6'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, rx_pin, cts_n, dsr_n, cd_n, ri_n, tx_pin, rts_n, dtr_n;
    int fails = 0, n_checks = 0, n;
    ufl_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n), .infrared_startup_pin(strap), .tx_pin(tx_pin),
        .rts_n(rts_n), .dtr_n(dtr_n));
    ufl_remote_port i_far (.hold_off(hold_off), .ir_mode(ir_mode), .rx_pin(rx_pin), .cts_n(cts_n),
        .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n));
    initial begin
        forever #10 pclk = ~pclk;
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one apb transfer; request held until pready is sampled high
    task apb(input logic w, input logic [3:0] idx, input logic [7:0] d, input logic [1:0] lo);
        psel <= 1'b1; pwrite <= w; paddr <= {idx, lo}; pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wr(input logic [3:0] idx, input logic [7:0] d); apb(1'b1, idx, d, 2'b00); endtask : wr
    task rdchk(input logic [3:0] idx, input logic [7:0] exp, input string what);
        apb(1'b0, idx, 8'h00, 2'b00);
        chk(what, {24'h00_0000, exp}, rd);
    endtask : rdchk
    task cyc(input int k); repeat (k) @(posedge pclk); endtask : cyc
    task t_regs;
        rdchk(REG_MCR, 8'h00, "modem control after reset");
        wr(REG_SPR, 8'h5a); rdchk(REG_SPR, 8'h5a, "scratch");
        apb(1'b1, REG_SPR, 8'h11, 2'b01); chk("misaligned error", 1, err);
        rdchk(REG_SPR, 8'h5a, "scratch kept");
        wr(REG_LCR, 8'h80); rdchk(REG_HOLD, DLL_RESET, "divisor low");
        wr(REG_IER, 8'h05); rdchk(REG_IER, 8'h05, "divisor high"); wr(REG_IER, 8'h00);
        wr(REG_LCR, 8'h00); rdchk(REG_IER, 8'h00, "interrupt enable");
        wr(REG_RX_FIFO_LEVEL, 8'h04); rdchk(REG_RX_FIFO_LEVEL, 8'h00, "rx fill count");
        wr(REG_RX_FIFO_LEVEL, RXTRIG_RESET);
        wr(REG_XOFF1, 8'h13); rdchk(REG_XOFF1, 8'h00, "flow char flags");
    endtask : t_regs
    task t_loop;
        wr(REG_MCR, 8'h13); cyc(8);
        chk("loop pins", 3'b111, {tx_pin, rts_n, dtr_n});
        rdchk(REG_MSR, 8'h00, "loop modem status");
        wr(REG_HOLD, 8'ha5); cyc(250);
        chk("loop tx pin", 1, tx_pin);
        rdchk(REG_HOLD, 8'ha5, "loop data");
        wr(REG_MCR, 8'h00);
    endtask : t_loop
    // flow input high before a char; the char must wait until it drops
    task t_flow(input logic [1:0] hold, input logic [7:0] modem_control);
        wr(REG_MCR, modem_control); wr(REG_EFR, 8'h90); wr(REG_IER, 8'h80);
        hold_off <= hold; cyc(10);
        rdchk(REG_ISR, 8'h21, "delta flow");
        wr(REG_HOLD, 8'h00); cyc(100);
        chk("tx held", 1, tx_pin);
        hold_off <= 2'b00;
        n = 0;
        while (tx_pin !== 1'b0 && n < 100) begin @(posedge pclk); n++; end
        chk("tx resumed", 1, n < 100);
        cyc(250); wr(REG_IER, 8'h00); wr(REG_EFR, 8'h00); wr(REG_MCR, 8'h00);
    endtask : t_flow
    // a zero char gives a pulse as wide as the chosen tick count
    task t_ir(input logic [7:0] frac, input logic [3:0] width);
        wr(REG_LCR, 8'h80); wr(REG_ISR, frac); wr(REG_LCR, 8'h00);
        chk("ir idle", 0, tx_pin);
        wr(REG_HOLD, 8'h00);
        n = 0;
        while (tx_pin !== 1'b1 && n < 300) begin @(posedge pclk); n++; end
        chk("ir pulse seen", 1, n < 300);
        n = 0;
        while (tx_pin === 1'b1 && n < 20) begin @(posedge pclk); n++; end
        chk("ir pulse width", {28'h000_0000, width}, n);
        cyc(250);
    endtask : t_ir
    // second reset with the strap high: infrared enable comes up set
    task t_strap;
        presetn <= 1'b0; strap <= 1'b1; cyc(2);
        presetn <= 1'b1; cyc(8);
        rdchk(REG_MCR, 8'h40, "modem control from strap");
        strap <= 1'b0; wr(REG_MCR, 8'h00);
        rdchk(REG_MCR, 8'h00, "strap bit overwritten");
    endtask : t_strap
    // auto rts started by software, then dropped and restored by the trigger level
    task t_rts;
        wr(REG_EFR, 8'h40); wr(REG_MCR, 8'h02); cyc(8);
        chk("auto rts asserted", 0, rts_n);
        wr(REG_RX_FIFO_LEVEL, 8'h00); cyc(4);
        chk("auto rts dropped", 1, rts_n);
        wr(REG_RX_FIFO_LEVEL, RXTRIG_RESET); cyc(4);
        chk("auto rts restored", 0, rts_n);
        wr(REG_MCR, 8'h00); wr(REG_EFR, 8'h00);
    endtask : t_rts
    task conclude;
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial begin
        #400_000;
        fails++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        cyc(8);
        chk("idle pins", 3'b111, {tx_pin, rts_n, dtr_n});
        t_regs();
        t_strap();
        t_rts();
        t_loop();
        t_flow(2'b01, 8'h00);
        t_flow(2'b10, 8'h04);
        ir_mode <= 1'b1;
        wr(REG_MCR, 8'h40); cyc(8);
        t_ir(8'h00, IR_WIDTH_STD);
        t_ir(8'h10, IR_WIDTH_FAST);
        conclude();
    end
endmodule : tb_ufl_channel
